// ### core/sgcr_defs.vh
// offsets, field positions, reset values and timing constants of the global control bank
`ifndef SGCR_DEFS_VH
`define SGCR_DEFS_VH

// register offsets
`define SGCR_OFS_MODE       8'h06
`define SGCR_OFS_STORM_LO   8'h07
`define SGCR_OFS_TEST_A     8'h08
`define SGCR_OFS_TEST_B     8'h09
`define SGCR_OFS_TEST_C     8'h0a
`define SGCR_OFS_CLKSEL     8'h0b
`define SGCR_OFS_MAP_LO     8'h0c
`define SGCR_OFS_MAP_HI     8'h0d

// field positions in the mode and clock select registers
`define SGCR_BIT_DUPLEX     6
`define SGCR_BIT_FLOWCTL    5
`define SGCR_BIT_SPEED      4
`define SGCR_BIT_NULLVID    3
`define SGCR_STORM_HI_MSB   2
`define SGCR_CLKSEL_MSB     7
`define SGCR_CLKSEL_LSB     6

// reset values
`define SGCR_RST_NULLVID    1'b0
`define SGCR_RST_STORM_HI   3'h0
`define SGCR_RST_STORM_LO   8'h63
`define SGCR_RST_TEST_A     8'h00
`define SGCR_RST_TEST_B     8'h24
`define SGCR_RST_TEST_C     8'h35
`define SGCR_RST_CLKSEL     2'h2
`define SGCR_CLKSEL_LOW_RO  6'h08
`define SGCR_RST_MAP_LO     8'h50
`define SGCR_RST_MAP_HI     8'hfa
`define SGCR_READ_ZERO      8'h00
// host port mode before the straps are captured
`define SGCR_RST_DUPLEX     1'b0
`define SGCR_RST_FLOWCTL    1'b1
`define SGCR_RST_SPEED      1'b0
// a vlan id of zero is the null id that may be replaced
`define SGCR_NULL_VID       12'h000

// clock select encodings
`define SGCR_CLK_31M25      2'h0
`define SGCR_CLK_62M5       2'h1
`define SGCR_CLK_125M       2'h2

// storm window timing: 40 MHz clock, 25 ns period
`define SGCR_CLK_PERIOD_NS  25
`define SGCR_WIN_100M_MS    67
`define SGCR_WIN_10M_MS     500
`define SGCR_NS_PER_MS      1000000
`define SGCR_BLOCK_BYTES    64
`define SGCR_CNT_W          25
`define SGCR_WIN_100M_CYC   25'd2680000
`define SGCR_WIN_10M_CYC    25'd20000000
// edges after release before the second strap stage holds pin levels
`define SGCR_STRAP_SETTLE   2'h2

`endif

// ### core/sgcr_storm_window.v
// storm interval timer and broadcast block budget check for one input port
`timescale 1ns/1ps
`include "sgcr_defs.vh"

module sgcr_storm_window #(
    parameter [24:0] WIN_100M_CYC = `SGCR_WIN_100M_CYC,  // 67 ms at 40 MHz
    parameter [24:0] WIN_10M_CYC  = `SGCR_WIN_10M_CYC    // 500 ms at 40 MHz
) (
    // clock and reset
    input  wire        clock,
    input  wire        rst,
    // configuration
    input  wire        speed_10m,        // 1 selects the long 10 Mbps window
    input  wire [10:0] storm_threshold,  // 64-byte blocks allowed per window
    // broadcast traffic
    input  wire        bcast_block,      // pulse: one 64-byte block of broadcast data
    output wire        bcast_accept,     // block may enter the port
    output reg         window_tick       // pulse at each window boundary
);
    reg [24:0] win_cnt_reg;   // cycles left in the window
    reg [10:0] blk_cnt_reg;   // blocks accepted this window

    // a block passes only while the budget is not yet used up
    assign bcast_accept = (blk_cnt_reg < storm_threshold);

    // interval timer and block counter; a speed change takes effect at the next reload
    always @(posedge clock) begin
        if (rst) begin
            win_cnt_reg <= 25'h0;
            blk_cnt_reg <= 11'h0;
            window_tick <= 1'b0;
        end else if (win_cnt_reg == 25'h0) begin
            win_cnt_reg <= (speed_10m ? WIN_10M_CYC : WIN_100M_CYC) - 25'h1;
            blk_cnt_reg <= 11'h0;
            window_tick <= 1'b1;
        end else begin
            win_cnt_reg <= win_cnt_reg - 25'h1;
            window_tick <= 1'b0;
            if (bcast_block && bcast_accept) begin
                blk_cnt_reg <= blk_cnt_reg + 11'h1;
            end
        end
    end
endmodule

// ### core/sgcr_global_ctrl.v
// global control bank of the three-port switch: host port mode, storm limit, priority map
`timescale 1ns/1ps
`include "sgcr_defs.vh"

module sgcr_global_ctrl #(
    parameter WIN_100M_CYC = `SGCR_WIN_100M_CYC,
    parameter WIN_10M_CYC  = `SGCR_WIN_10M_CYC
) (
    // clock and reset
    input  wire        clock,
    input  wire        rst,
    // strap pins, asynchronous to clock
    input  wire        duplex_strap_pin,
    input  wire        flow_control_strap_pin,
    input  wire        host_port_speed_strap_pin,
    // register port from the management interfaces
    input  wire [7:0]  reg_addr,
    input  wire        reg_wr,
    input  wire [7:0]  reg_wdata,
    input  wire        reg_rd,
    output reg  [7:0]  reg_rdata,
    // host port mode
    output wire        host_port_half_duplex,
    output wire        host_port_flow_ctl_en,
    output wire        host_port_10m,
    // vlan tag handling
    input  wire [11:0] frame_vid,
    input  wire [11:0] port_default_vid,
    output reg  [11:0] frame_vid_out,
    // priority mapping
    input  wire [2:0]  frame_tag_prio,
    output reg  [1:0]  egress_queue,
    output reg  [3:0]  egress_queue_onehot,
    // storm protection
    input  wire        bcast_block,
    output wire        bcast_accept,
    output wire        storm_window_tick,
    // interface clock choice
    output wire [1:0]  cpu_if_clk_sel
);
    // strap synchronisers: first stage feeds only the second
    reg [2:0] strap_s1_reg;
    reg [2:0] strap_s2_reg;
    reg       strap_loaded_reg;    // straps taken once after reset release
    reg [1:0] strap_wait_reg;      // edges since release, until capture

    // writable fields
    reg       half_duplex_reg;
    reg       flow_ctl_reg;
    reg       speed_10m_reg;
    reg       null_vid_reg;
    reg [2:0] storm_hi_reg;
    reg [7:0] storm_lo_reg;
    reg [1:0] clk_sel_reg;
    reg [7:0] map_lo_reg;
    reg [7:0] map_hi_reg;

    wire [10:0] storm_threshold;

    // read decode, used only for read data; writes decode the address themselves
    function [7:0] sgcr_field;
        input [7:0] addr;
        input [7:0] mode_byte;
        input [7:0] storm_lo;
        input [7:0] clk_byte;
        input [7:0] map_lo;
        input [7:0] map_hi;
        begin
            case (addr)
                `SGCR_OFS_MODE:     sgcr_field = mode_byte;
                `SGCR_OFS_STORM_LO: sgcr_field = storm_lo;
                `SGCR_OFS_TEST_A:   sgcr_field = `SGCR_RST_TEST_A;
                `SGCR_OFS_TEST_B:   sgcr_field = `SGCR_RST_TEST_B;
                `SGCR_OFS_TEST_C:   sgcr_field = `SGCR_RST_TEST_C;
                `SGCR_OFS_CLKSEL:   sgcr_field = clk_byte;
                `SGCR_OFS_MAP_LO:   sgcr_field = map_lo;
                `SGCR_OFS_MAP_HI:   sgcr_field = map_hi;
                default:            sgcr_field = `SGCR_READ_ZERO;
            endcase
        end
    endfunction

    // pick a 2-bit map entry by tag value
    function [1:0] sgcr_map_pick;
        input [7:0] map;
        input [1:0] idx;
        begin
            sgcr_map_pick = map[idx*2 +: 2];
        end
    endfunction

    assign host_port_half_duplex = half_duplex_reg;
    assign host_port_flow_ctl_en = flow_ctl_reg;
    assign host_port_10m         = speed_10m_reg;
    assign cpu_if_clk_sel        = clk_sel_reg;
    assign storm_threshold       = {storm_hi_reg, storm_lo_reg};

    // two-flop strap synchroniser
    always @(posedge clock) begin
        if (rst) begin
            strap_s1_reg <= 3'h0;
            strap_s2_reg <= 3'h0;
        end else begin
            strap_s1_reg <= {duplex_strap_pin, flow_control_strap_pin,
                             host_port_speed_strap_pin};
            strap_s2_reg <= strap_s1_reg;
        end
    end

    // register file; straps load once when the synchroniser has settled
    always @(posedge clock) begin
        if (rst) begin
            strap_loaded_reg <= 1'b0;
            strap_wait_reg   <= 2'h0;
            half_duplex_reg  <= `SGCR_RST_DUPLEX;
            flow_ctl_reg     <= `SGCR_RST_FLOWCTL;
            speed_10m_reg    <= `SGCR_RST_SPEED;
            null_vid_reg     <= `SGCR_RST_NULLVID;
            storm_hi_reg     <= `SGCR_RST_STORM_HI;
            storm_lo_reg     <= `SGCR_RST_STORM_LO;
            clk_sel_reg      <= `SGCR_RST_CLKSEL;
            map_lo_reg       <= `SGCR_RST_MAP_LO;
            map_hi_reg       <= `SGCR_RST_MAP_HI;
        end else if (!strap_loaded_reg) begin
            // count edges instead of peeking at the first stage, which may be metastable
            if (strap_wait_reg == `SGCR_STRAP_SETTLE) begin
                strap_loaded_reg <= 1'b1;
                half_duplex_reg  <= strap_s2_reg[2];
                flow_ctl_reg     <= strap_s2_reg[1];
                speed_10m_reg    <= strap_s2_reg[0];
            end else begin
                // second stage not yet holding pin levels
                strap_wait_reg   <= strap_wait_reg + 2'h1;
            end
        end else if (reg_wr) begin
            case (reg_addr)
                `SGCR_OFS_MODE: begin
                    half_duplex_reg <= reg_wdata[`SGCR_BIT_DUPLEX];
                    flow_ctl_reg    <= reg_wdata[`SGCR_BIT_FLOWCTL];
                    speed_10m_reg   <= reg_wdata[`SGCR_BIT_SPEED];
                    null_vid_reg    <= reg_wdata[`SGCR_BIT_NULLVID];
                    storm_hi_reg    <= reg_wdata[`SGCR_STORM_HI_MSB:0];
                end
                `SGCR_OFS_STORM_LO: begin
                    storm_lo_reg <= reg_wdata;
                end
                `SGCR_OFS_CLKSEL: begin
                    clk_sel_reg <= reg_wdata[`SGCR_CLKSEL_MSB:`SGCR_CLKSEL_LSB];
                end
                `SGCR_OFS_MAP_LO: begin
                    map_lo_reg <= reg_wdata;
                end
                `SGCR_OFS_MAP_HI: begin
                    map_hi_reg <= reg_wdata;
                end
                default: begin
                    map_hi_reg <= map_hi_reg;
                end
            endcase
        end
    end

    // read data registered one cycle after the read strobe
    always @(posedge clock) begin
        if (rst) begin
            reg_rdata <= `SGCR_READ_ZERO;
        end else if (reg_rd) begin
            reg_rdata <= sgcr_field(reg_addr,
                {1'b0, half_duplex_reg, flow_ctl_reg, speed_10m_reg,
                 null_vid_reg, storm_hi_reg},
                storm_lo_reg,
                {clk_sel_reg, `SGCR_CLKSEL_LOW_RO},
                map_lo_reg, map_hi_reg);
        end
    end

    // vid substitution and queue choice, registered for clean data outputs
    always @(posedge clock) begin
        if (rst) begin
            frame_vid_out       <= 12'h000;
            egress_queue        <= 2'h0;
            egress_queue_onehot <= 4'h1;
        end else begin
            if (null_vid_reg && frame_vid == `SGCR_NULL_VID) begin
                frame_vid_out <= port_default_vid;
            end else begin
                frame_vid_out <= frame_vid;
            end
            egress_queue <= sgcr_map_pick(frame_tag_prio[2] ? map_hi_reg : map_lo_reg,
                                          frame_tag_prio[1:0]);
            // value three is the top queue, bit 3 of the one-hot
            egress_queue_onehot <= 4'h1 << sgcr_map_pick(
                frame_tag_prio[2] ? map_hi_reg : map_lo_reg, frame_tag_prio[1:0]);
        end
    end

    sgcr_storm_window #(
        .WIN_100M_CYC (WIN_100M_CYC),
        .WIN_10M_CYC  (WIN_10M_CYC)
    ) u_storm (
        .clock           (clock),
        .rst             (rst),
        .speed_10m       (speed_10m_reg),
        .storm_threshold (storm_threshold),
        .bcast_block     (bcast_block),
        .bcast_accept    (bcast_accept),
        .window_tick     (storm_window_tick)
    );
endmodule

// ### verification/sgcr_global_ctrl_props.sv
// assertion checker for the global control bank
`timescale 1ns/1ps
module sgcr_global_ctrl_props (
    // clock and reset
    input wire       clock,
    input wire       rst,
    // register port
    input wire [7:0] reg_addr,
    input wire       reg_wr,
    input wire [7:0] reg_wdata,
    input wire       reg_rd,
    input wire [7:0] reg_rdata,
    // decoded outputs
    input wire       host_port_half_duplex,
    input wire       host_port_flow_ctl_en,
    input wire       host_port_10m,
    input wire [1:0] egress_queue,
    input wire [3:0] egress_queue_onehot,
    input wire       storm_window_tick,
    input wire [1:0] cpu_if_clk_sel
);
    // edges since release; earlier writes are dropped while straps settle
    reg [2:0] up_reg;
    always @(posedge clock) begin
        up_reg <= rst ? 3'h0 : (up_reg == 3'h7 ? up_reg : up_reg + 3'h1);
    end
    wire ready  = up_reg >= 3'h3;
    wire mode_w = ready && reg_wr && reg_addr == 8'h06;
    wire sel_w  = ready && reg_wr && reg_addr == 8'h0b;
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    dup_wr_a: assert property (mode_w
        |=> host_port_half_duplex == $past(reg_wdata[6])) else $error("duplex wrong");
    flow_wr_a: assert property (mode_w
        |=> host_port_flow_ctl_en == $past(reg_wdata[5])) else $error("flow wrong");
    speed_wr_a: assert property (mode_w
        |=> host_port_10m == $past(reg_wdata[4])) else $error("speed wrong");
    reset_mode_a: assert property (disable iff (1'b0) rst
        |=> host_port_flow_ctl_en && !host_port_half_duplex && cpu_if_clk_sel == 2'h2)
        else $error("reset value wrong");
    clk_sel_a: assert property (sel_w
        |=> cpu_if_clk_sel == $past(reg_wdata[7:6])) else $error("clock select wrong");
    test_read_a: assert property (ready && reg_rd && reg_addr == 8'h09
        |=> reg_rdata == 8'h24) else $error("test register wrong");
    queue_hot_a: assert property (egress_queue_onehot == 4'h1 << egress_queue)
        else $error("one-hot queue wrong");
    tick_gap_a: assert property (storm_window_tick
        |=> !storm_window_tick [*8]) else $error("window too short");
endmodule
bind sgcr_global_ctrl sgcr_global_ctrl_props u_props (
    .clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .host_port_half_duplex(host_port_half_duplex), .host_port_10m(host_port_10m),
    .host_port_flow_ctl_en(host_port_flow_ctl_en), .egress_queue(egress_queue),
    .egress_queue_onehot(egress_queue_onehot), .storm_window_tick(storm_window_tick),
    .cpu_if_clk_sel(cpu_if_clk_sel));

// ### verification/sgcr_host_model.sv
// host processor model driving the register port
`timescale 1ns/1ps
module sgcr_host_model (
    // clock
    input  wire       clock,
    // register port
    output reg  [7:0] reg_addr,
    output reg        reg_wr,
    output reg  [7:0] reg_wdata,
    output reg        reg_rd,
    input  wire [7:0] reg_rdata
);
    // idle bus at start, address on an unmapped place
    initial begin
        reg_addr = 8'hff;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
        reg_rd = 1'b0;
    end
    // single-edge write; released lines show inverted data, never stale
    task wr(input [7:0] a, input [7:0] d);
        begin
            @(negedge clock);
            reg_addr = a;
            reg_wdata = d;
            reg_wr = 1'b1;
            @(negedge clock);
            reg_wr = 1'b0;
            reg_addr = ~a;
            reg_wdata = ~d;
        end
    endtask
    // read strobe; registered data is settled by the next falling edge
    task rd(input [7:0] a, output [7:0] d);
        begin
            @(negedge clock);
            reg_addr = a;
            reg_rd = 1'b1;
            @(negedge clock);
            reg_rd = 1'b0;
            reg_addr = ~a;
            d = reg_rdata;
        end
    endtask
endmodule

// ### verification/testbench.sv
// self-checking bench for the global control bank
`timescale 1ns/1ps
`define CHK(nm, ex, ac) begin n_tests++; if ((ac) !== (ex)) begin mismatches++; \
    $display("unexpected %s exp %h seen %h", nm, ex, ac); end end
module testbench;
    // clock, reset, strap levels {duplex, flow, speed}
    reg         clock = 1'b0;
    reg         rst = 1'b1;
    reg  [2:0]  strap = 3'h2;
    // datapath stimulus
    reg  [11:0] frame_vid = 12'h0;
    reg  [2:0]  frame_tag_prio = 3'h0;
    reg         bcast_block = 1'b0;
    // register port and outputs
    wire [7:0]  reg_addr, reg_wdata, reg_rdata;
    wire        reg_wr, reg_rd, half, flow, slow, accept, tick;
    wire [11:0] vid_out;
    wire [1:0]  queue, clk_sel;
    wire [3:0]  onehot;
    // bookkeeping
    int         mismatches = 0;
    int         n_tests = 0;
    int         cycles = 0;
    int         k;
    reg  [7:0]  q;
    // rows: offset, data written, readback; slowest clock in row 6
    reg  [23:0] rows [0:11] = '{24'h06ff7f, 24'h060000, 24'h07a5a5, 24'h08ff00,
        24'h090024, 24'h0a0035, 24'h0b3f08, 24'h0b4048, 24'h0b8088, 24'h0ce4e4,
        24'h0d1b1b, 24'h20ff00};
    // reset readback: offset, value with straps {1,0,1}
    reg  [15:0] rvals [0:4] = '{16'h0650, 16'h0763, 16'h0b88, 16'h0c50, 16'h0dfa};
    always #12.5 clock = ~clock;
    // short windows keep the storm test brief
    sgcr_global_ctrl #(.WIN_100M_CYC(25'd20), .WIN_10M_CYC(25'd50)) u_sgcr_global_ctrl (
        .clock(clock), .rst(rst), .duplex_strap_pin(strap[2]),
        .flow_control_strap_pin(strap[1]), .host_port_speed_strap_pin(strap[0]),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .host_port_half_duplex(half), .host_port_flow_ctl_en(flow),
        .host_port_10m(slow), .frame_vid(frame_vid), .port_default_vid(12'habc),
        .frame_vid_out(vid_out), .frame_tag_prio(frame_tag_prio), .egress_queue(queue),
        .egress_queue_onehot(onehot), .bcast_block(bcast_block), .bcast_accept(accept),
        .storm_window_tick(tick), .cpu_if_clk_sel(clk_sel));
    sgcr_host_model u_sgcr_host_model (.clock(clock), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    // hang guard: the run needs a few hundred cycles
    always @(posedge clock) begin
        cycles++;
        if (cycles == 2000) begin
            mismatches++;
            print_verdict;
        end
    end
    task print_verdict;
        begin
            $display("checks %0d mismatches %0d", n_tests, mismatches);
            if (mismatches == 0 && n_tests > 0) $display("NO MISMATCHES");
            else $display("MISMATCHES SEEN");
            $finish;
        end
    endtask
    // 16 cycles of reset, then let the straps settle
    task do_reset(input [2:0] s);
        begin
            rst = 1'b1;
            strap = s;
            repeat (16) @(negedge clock);
            rst = 1'b0;
            repeat (4) @(negedge clock);
        end
    endtask
    initial begin
        do_reset(3'h2);
        for (k = 0; k < 12; k++) begin
            u_sgcr_host_model.wr(rows[k][23:16], rows[k][15:8]);
            u_sgcr_host_model.rd(rows[k][23:16], q);
            `CHK("readback", rows[k][7:0], q)
        end
        $display("test rows done");
        do_reset(3'h5);
        `CHK("half", 1'b1, half)
        `CHK("slow", 1'b1, slow)
        `CHK("flow", 1'b0, flow)
        `CHK("clk sel", 2'h2, clk_sel)
        for (k = 0; k < 5; k++) begin
            u_sgcr_host_model.rd(rvals[k][15:8], q);
            `CHK("reset value", rvals[k][7:0], q)
        end
        $display("test reset done");
        frame_tag_prio = 3'h7;
        @(negedge clock);
        `CHK("queue7", 2'h3, queue)
        u_sgcr_host_model.wr(8'h0c, 8'he4);
        for (k = 0; k < 4; k++) begin
            frame_tag_prio = k[2:0];
            @(negedge clock);
            `CHK("queue", k[1:0], queue)
            `CHK("onehot", 4'h1 << k, onehot)
        end
        $display("test map done");
        u_sgcr_host_model.wr(8'h06, 8'h08);
        @(negedge clock);
        `CHK("vid null", 12'habc, vid_out)
        frame_vid = 12'h005;
        @(negedge clock);
        `CHK("vid kept", 12'h005, vid_out)
        $display("test vid done");
        // threshold of three blocks, 100 Mbps window
        u_sgcr_host_model.wr(8'h07, 8'h03);
        @(posedge tick);
        @(negedge clock);
        @(negedge clock);
        bcast_block = 1'b1;
        q = 8'h00;
        repeat (15) begin
            q = q + {7'h0, accept};
            @(negedge clock);
        end
        bcast_block = 1'b0;
        `CHK("blocks", 8'h03, q)
        // 10 Mbps takes the long window from the next reload on
        u_sgcr_host_model.wr(8'h06, 8'h10);
        @(posedge tick);
        @(negedge clock);
        k = 0;
        do begin
            k++;
            @(negedge clock);
        end while (!tick);
        `CHK("window 10m", 50, k)
        $display("test storm done");
        print_verdict;
    end
endmodule
